// ---- logic/fspc_flash_ctrl.sv ----
// Flash self-program sequencer with Wishbone register slave
//
// Our own choices: the register addresses and the Wishbone slave port.
`include "fspc_defs.svh"
module fspc_flash_ctrl #(
    parameter int LATCHES   = 32,
    parameter int ROWS      = 1024,
    parameter int PROG_CYC  = `FSPC_PROG_TIME_NS / `FSPC_CLK_PERIOD_NS,
    parameter logic [13:0] DEV_ID = 14'h1234, // Arbitrary value
    parameter logic [13:0] CFG_WORD1 = 14'h3fff,
    parameter logic [13:0] CFG_WORD2 = 14'h3fff
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Status
    output logic             busy_o,
    output logic             irq_o
);
    import fspc_pkg::*;

    localparam int LW = $clog2(LATCHES);
    localparam int RW = $clog2(ROWS);
    localparam int CW = $clog2(PROG_CYC + 1);

    logic [13:0] flash_mem [0:LATCHES*ROWS-1];
    logic [13:0] latch     [0:LATCHES-1];
    logic [13:0] user_id   [0:3];

    logic [7:0]  data_low, next_data_low;
    logic [5:0]  data_high, next_data_high;
    logic [7:0]  addr_low, next_addr_low;
    logic [6:0]  addr_high, next_addr_high;
    logic        cfgsel, next_cfgsel;
    logic        llo, next_llo;
    logic        erase, next_erase;
    logic        err, next_err;
    logic        pen, next_pen;
    logic        wr_trig, next_wr_trig;
    logic [1:0]  irq_stat, next_irq_stat;
    logic [1:0]  irq_mask, next_irq_mask;
    logic        ack, next_ack;
    logic [31:0] rdata, next_rdata;
    fspc_unlock_t unl, next_unl;
    fspc_op_t    op, next_op;
    logic [CW-1:0] cnt, next_cnt;

    logic        req, wreq, rreq;
    logic [3:0]  idx;
    logic [14:0] addr;
    logic [13:0] word;
    logic        start, rd_now, ld_latch, uid_wr;
    logic [13:0] rd_word;
    logic        rd_ok;

    assign addr = {addr_high, addr_low};
    assign word = {data_high, data_low};
    assign idx  = wb_adr_i[5:2];
    // Stall the processor while a self-timed operation runs
    assign req  = wb_cyc_i && wb_stb_i && !ack && op == FSPC_OP_IDLE;
    assign wreq = req && wb_we_i && wb_sel_i[0];
    assign rreq = req && !wb_we_i;

    always_comb begin
        rd_ok   = 1'b1;
        rd_word = 14'h0000;
        if (cfgsel) begin
            if (addr <= `FSPC_UID_LAST) begin
                rd_word = user_id[addr[1:0]];
            end else if (addr == `FSPC_DEVID_ADDR) begin
                rd_word = DEV_ID;
            end else if (addr == `FSPC_CFG_FIRST) begin
                rd_word = CFG_WORD1;
            end else if (addr == `FSPC_CFG_LAST) begin
                rd_word = CFG_WORD2;
            end else begin
                rd_ok = 1'b0;
            end
        end else begin
            rd_word = flash_mem[addr[LW+RW-1:0]];
        end
    end

    always_comb begin
        next_data_low  = data_low;
        next_data_high = data_high;
        next_addr_low  = addr_low;
        next_addr_high = addr_high;
        next_cfgsel    = cfgsel;
        next_llo       = llo;
        next_erase     = erase;
        next_err       = err;
        next_pen       = pen;
        next_wr_trig   = wr_trig;
        next_irq_stat  = irq_stat;
        next_irq_mask  = irq_mask;
        next_unl       = unl;
        next_op        = op;
        next_cnt       = cnt;
        next_ack       = req;
        next_rdata     = 32'h0000_0000;
        start          = 1'b0;
        rd_now         = 1'b0;
        ld_latch       = 1'b0;
        uid_wr         = 1'b0;
        // Any access other than the next expected step drops the unlock
        if (req && !(wreq && idx == `FSPC_REG_UNLOCK)
                && !(wreq && idx == `FSPC_REG_CONTROL)) begin
            if (unl != FSPC_UNL_IDLE) begin
                next_irq_stat[`FSPC_IRQ_ABORT] = 1'b1;
            end
            next_unl = FSPC_UNL_IDLE;
        end
        if (wreq) begin
            unique case (idx)
                `FSPC_REG_DATA_LOW:  next_data_low = wb_dat_i[7:0];
                `FSPC_REG_DATA_HIGH: next_data_high = wb_dat_i[5:0];
                `FSPC_REG_ADDR_LOW:  next_addr_low = wb_dat_i[7:0];
                `FSPC_REG_ADDR_HIGH: next_addr_high = wb_dat_i[6:0];
                `FSPC_REG_UNLOCK: begin
                    if (unl == FSPC_UNL_IDLE
                            && wb_dat_i[7:0] == `FSPC_UNLOCK_FIRST) begin
                        next_unl = FSPC_UNL_GOT_FIRST;
                    end else if (unl == FSPC_UNL_GOT_FIRST
                            && wb_dat_i[7:0] == `FSPC_UNLOCK_SECOND) begin
                        next_unl = FSPC_UNL_ARMED;
                    end else begin
                        next_unl = FSPC_UNL_IDLE;
                    end
                end
                `FSPC_REG_CONTROL: begin
                    next_cfgsel = wb_dat_i[`FSPC_BIT_CFGSEL];
                    next_llo    = wb_dat_i[`FSPC_BIT_LLO];
                    next_erase  = wb_dat_i[`FSPC_BIT_ERASE];
                    next_err    = wb_dat_i[`FSPC_BIT_ERR];
                    next_pen    = wb_dat_i[`FSPC_BIT_PEN];
                    next_unl    = FSPC_UNL_IDLE;
                    if (wb_dat_i[`FSPC_BIT_WRITE]) begin
                        next_err = 1'b1;
                        if (unl == FSPC_UNL_ARMED
                                && wb_dat_i[`FSPC_BIT_PEN] && pen) begin
                            start = 1'b1;
                        end else if (unl != FSPC_UNL_IDLE) begin
                            next_irq_stat[`FSPC_IRQ_ABORT] = 1'b1;
                        end
                    end else if (unl != FSPC_UNL_IDLE) begin
                        next_irq_stat[`FSPC_IRQ_ABORT] = 1'b1;
                    end
                    if (wb_dat_i[`FSPC_BIT_READ]) begin
                        rd_now = 1'b1;
                    end
                end
                `FSPC_REG_IRQ_MASK:  next_irq_mask = wb_dat_i[1:0];
                default: ;
            endcase
        end
        if (start) begin
            next_wr_trig = 1'b1;
            if (wb_dat_i[`FSPC_BIT_ERASE]) begin
                next_op  = FSPC_OP_ERASE;
                next_cnt = CW'(PROG_CYC);
            end else if (cfgsel || wb_dat_i[`FSPC_BIT_CFGSEL]) begin
                // Only user ID words accept writes in config space
                uid_wr   = wb_dat_i[`FSPC_BIT_CFGSEL]
                           && addr <= `FSPC_UID_LAST;
                next_err = 1'b0;
            end else begin
                ld_latch = 1'b1;
                if (wb_dat_i[`FSPC_BIT_LLO]) begin
                    next_err = 1'b0;
                    next_wr_trig = 1'b0;
                end else begin
                    next_op  = FSPC_OP_PROGRAM;
                    next_cnt = CW'(PROG_CYC);
                end
            end
            if (uid_wr || (!wb_dat_i[`FSPC_BIT_ERASE]
                    && wb_dat_i[`FSPC_BIT_CFGSEL])) begin
                next_wr_trig = 1'b0;
            end
        end
        if (rd_now) begin
            next_data_low  = rd_ok ? rd_word[7:0] : 8'h00;
            next_data_high = rd_ok ? rd_word[13:8] : 6'h00;
        end
        if (op != FSPC_OP_IDLE) begin
            if (cnt <= CW'(1)) begin
                next_op      = FSPC_OP_IDLE;
                next_wr_trig = 1'b0;
                next_err     = 1'b0;
                next_irq_stat[`FSPC_IRQ_DONE] = 1'b1;
                if (op == FSPC_OP_ERASE) begin
                    next_erase = 1'b0;
                end
            end else begin
                next_cnt = cnt - CW'(1);
            end
        end
        if (rreq) begin
            unique case (idx)
                `FSPC_REG_DATA_LOW:  next_rdata[7:0] = data_low;
                `FSPC_REG_DATA_HIGH: next_rdata[7:0] = {2'b00, data_high};
                `FSPC_REG_ADDR_LOW:  next_rdata[7:0] = addr_low;
                `FSPC_REG_ADDR_HIGH: next_rdata[7:0] = {1'b1, addr_high};
                `FSPC_REG_CONTROL:   next_rdata[7:0] = {1'b1, cfgsel, llo,
                                         erase, err, pen, wr_trig, 1'b0};
                `FSPC_REG_IRQ_STATUS: begin
                    next_rdata[1:0] = irq_stat;
                    // Read clears, but an event in the same cycle survives
                    next_irq_stat = next_irq_stat & ~irq_stat;
                    if (op != FSPC_OP_IDLE && cnt <= CW'(1)) begin
                        next_irq_stat[`FSPC_IRQ_DONE] = 1'b1;
                    end
                    // This read itself drops a partial unlock: keep that
                    if (unl != FSPC_UNL_IDLE) begin
                        next_irq_stat[`FSPC_IRQ_ABORT] = 1'b1;
                    end
                end
                `FSPC_REG_IRQ_MASK:  next_rdata[1:0] = irq_mask;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_low  <= 8'h00;
            data_high <= 6'h00;
            addr_low  <= 8'h00;
            addr_high <= 7'h00;
            cfgsel    <= 1'b0;
            llo       <= 1'b0;
            erase     <= 1'b0;
            err       <= 1'b0;
            pen       <= 1'b0;
            wr_trig   <= 1'b0;
            irq_stat  <= 2'b00;
            irq_mask  <= 2'b00;
            unl       <= FSPC_UNL_IDLE;
            op        <= FSPC_OP_IDLE;
            cnt       <= '0;
            ack       <= 1'b0;
            rdata     <= 32'h0000_0000;
        end else begin
            data_low  <= next_data_low;
            data_high <= next_data_high;
            addr_low  <= next_addr_low;
            addr_high <= next_addr_high;
            cfgsel    <= next_cfgsel;
            llo       <= next_llo;
            erase     <= next_erase;
            err       <= next_err;
            pen       <= next_pen;
            wr_trig   <= next_wr_trig;
            irq_stat  <= next_irq_stat;
            irq_mask  <= next_irq_mask;
            unl       <= next_unl;
            op        <= next_op;
            cnt       <= next_cnt;
            ack       <= next_ack;
            rdata     <= next_rdata;
        end
    end

    // Array storage has no reset; blank latches are restored after each op
    logic finish;
    assign finish = op != FSPC_OP_IDLE && cnt <= CW'(1);

    genvar g;
    generate
        for (g = 0; g < LATCHES; g++) begin : g_latch
            always_ff @(posedge clk_i) begin
                if (rst_i || finish) begin
                    latch[g] <= `FSPC_BLANK_WORD;
                end else if (ld_latch && addr[LW-1:0] == LW'(g)) begin
                    latch[g] <= word;
                end
            end
            always_ff @(posedge clk_i) begin
                if (finish && op == FSPC_OP_ERASE) begin
                    flash_mem[{addr[LW+RW-1:LW], LW'(g)}] <= `FSPC_BLANK_WORD;
                end else if (finish) begin
                    flash_mem[{addr[LW+RW-1:LW], LW'(g)}] <= latch[g];
                end
            end
        end
        for (g = 0; g < 4; g++) begin : g_uid
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    user_id[g] <= `FSPC_BLANK_WORD;
                end else if (uid_wr && addr[1:0] == 2'(g)) begin
                    user_id[g] <= word;
                end
            end
        end
    endgenerate

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign busy_o   = op != FSPC_OP_IDLE;
    assign irq_o    = |(irq_stat & irq_mask);
endmodule // fspc_flash_ctrl

// ---- common/fspc_defs.svh ----
// Constants for the flash self-program control block
// Summary of operation
// - Space select 1 targets ID/config words; 0 targets program flash. Erase still clears a program flash row with select 1.
// - User IDs 8000h-8003h read/write; device ID 8006h, config 8007h-8008h read-only.
// - Config-space read outside accessible addresses clears both data registers.
// - Word is 14 bits; data high bits 7-6 read zero.
// - Address is 15 bits; address high bit 7 reads one.
// - Latch-load-only set: write trigger loads addressed latch only.
// - Latch-load-only clear: load latch then program all latches to the row.
// - Erase select performs row erase, cleared by hardware on completion.
// - Erase ignores latch-load-only.
// - Error flag set on any attempt to set write trigger, except a started latch-load-only or config-space write.
// - Program enable clear inhibits programming and erasing.
// - Write trigger set-only by software, cleared by hardware when done.
// - Read trigger set-only, one-cycle read loads data, then self-clears.
// - Interrupted unlock sequence loads no latch and starts no programming.
// - All write latches return to 3FFFh after every row program or erase; a latch-load-only write and a user ID write leave them as they are.
// - Low five address bits pick the latch; upper ten bits give the row.
`ifndef FSPC_DEFS_SVH
`define FSPC_DEFS_SVH
`define FSPC_REG_DATA_LOW    4'h0
`define FSPC_REG_DATA_HIGH   4'h1
`define FSPC_REG_ADDR_LOW    4'h2
`define FSPC_REG_ADDR_HIGH   4'h3
`define FSPC_REG_CONTROL     4'h4
`define FSPC_REG_UNLOCK      4'h5
`define FSPC_REG_IRQ_STATUS  4'h6
`define FSPC_REG_IRQ_MASK    4'h7
`define FSPC_BIT_CFGSEL      6
`define FSPC_BIT_LLO         5
`define FSPC_BIT_ERASE       4
`define FSPC_BIT_ERR         3
`define FSPC_BIT_PEN         2
`define FSPC_BIT_WRITE       1
`define FSPC_BIT_READ        0
`define FSPC_UNLOCK_FIRST    8'h55
`define FSPC_UNLOCK_SECOND   8'haa
`define FSPC_BLANK_WORD      14'h3fff
`define FSPC_UID_FIRST       15'h0000
`define FSPC_UID_LAST        15'h0003
`define FSPC_DEVID_ADDR      15'h0006
`define FSPC_CFG_FIRST       15'h0007
`define FSPC_CFG_LAST        15'h0008
`define FSPC_IRQ_DONE        0
`define FSPC_IRQ_ABORT       1
`define FSPC_PROG_TIME_NS    2000
`define FSPC_CLK_PERIOD_NS   4
`endif

// ---- common/fspc_pkg.sv ----
// Types for the flash self-program control block
package fspc_pkg;
    typedef enum logic [1:0] {
        FSPC_UNL_IDLE,
        FSPC_UNL_GOT_FIRST,
        FSPC_UNL_ARMED
    } fspc_unlock_t;
    typedef enum logic [1:0] {
        FSPC_OP_IDLE,
        FSPC_OP_PROGRAM,
        FSPC_OP_ERASE
    } fspc_op_t;
endpackage

// ---- bench/fspc_flash_ctrl_asserts.sv ----
// Concurrent checks on the ports of the flash self-program control block
module fspc_flash_ctrl_chk #(
    parameter int PROG_CYC = 500
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Status
    input wire logic        busy_o,
    input wire logic        irq_o
);
    int unsigned busy_cnt;
    logic        rd_ack;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Busy cycles of the stretch before this one; full length in the first idle cycle, zero after
    always_ff @(posedge clk_i) begin
        busy_cnt <= (rst_i || !busy_o) ? 0 : busy_cnt + 1;
    end
    assign rd_ack = wb_ack_o && !wb_we_i;
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");
    property p_ack_req; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("ack without a request");
    property p_stall; busy_o && $past(busy_o) |-> !wb_ack_o; endproperty
    a_stall: assert property (p_stall)
        else $error("request answered while busy");
    property p_busy_len; $fell(busy_o) |-> busy_cnt == PROG_CYC; endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("self-timed operation has wrong length");
    property p_busy_cause;
        $rose(busy_o) |-> $past(wb_we_i && wb_adr_i[5:2] == 4'h4
                                && wb_dat_i[2:1] == 2'b11);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("operation started without enabled trigger");
    property p_data_high;
        rd_ack && wb_adr_i[5:2] == 4'h1 |-> wb_dat_o[31:6] == 26'h0;
    endproperty
    a_data_high: assert property (p_data_high)
        else $error("data high upper bits not zero");
    property p_addr_high;
        rd_ack && wb_adr_i[5:2] == 4'h3 |-> wb_dat_o[7];
    endproperty
    a_addr_high: assert property (p_addr_high)
        else $error("address high bit 7 not one");
    property p_ctl_read;
        rd_ack && wb_adr_i[5:2] == 4'h4 |-> wb_dat_o[7] && !wb_dat_o[0];
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control read shows wrong fixed bits");
endmodule // fspc_flash_ctrl_chk

bind fspc_flash_ctrl fspc_flash_ctrl_chk #(.PROG_CYC(PROG_CYC))
    i_fspc_flash_ctrl_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o),
    .irq_o(irq_o));

// ---- bench/fspc_flash_ctrl_test.sv ----
// Self-checking bench for the flash self-program control block
module fspc_flash_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] DID = 14'h0a5c; // Arbitrary value
    localparam logic [13:0] CW1 = 14'h2b1e;
    localparam logic [13:0] CW2 = 14'h1c07;
    logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0;
    logic        wb_we_i = 0, busy_seen, irq_seen, wb_ack_o, busy_o, irq_o;
    logic [5:0]  wb_adr_i = '0;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = '0;
    logic [31:0] wb_dat_o;
    logic [7:0]  q, d;
    logic [13:0] w0, w1, w2, uid;
    logic [14:0] row;
    int          mismatches = 0, samples_checked = 0, cycles = 0;
    fspc_flash_ctrl #(.PROG_CYC(4), .DEV_ID(DID), .CFG_WORD1(CW1),
        .CFG_WORD2(CW2)) i_fspc_flash_ctrl (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o),
        .irq_o(irq_o));
    initial forever #2 clk_i = ~clk_i;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Entered just after a rising edge; ack and data are taken at an edge
    task automatic xfer(input logic we, input logic [3:0] idx,
                        input logic [7:0] v);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, v};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o[7:0];
        busy_seen = busy_o;
        irq_seen = irq_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdc(input logic [3:0] idx, input logic [7:0] e);
        xfer(1'b0, idx, 8'h00);
        chk({8'h0, q}, {8'h0, e});
    endtask
    // Address, data and mode set up, then unlock and fire the trigger
    task automatic op(input logic [7:0] mode, input logic [14:0] a,
                      input logic [13:0] w, input logic brk);
        xfer(1'b1, 4'h2, a[7:0]);
        xfer(1'b1, 4'h3, {1'b0, a[14:8]});
        xfer(1'b1, 4'h0, w[7:0]);
        xfer(1'b1, 4'h1, {2'b00, w[13:8]});
        xfer(1'b1, 4'h4, mode);
        xfer(1'b1, 4'h5, 8'h55);
        if (brk) xfer(1'b0, 4'h0, 8'h00);
        xfer(1'b1, 4'h5, 8'haa);
        xfer(1'b1, 4'h4, mode | 8'h02);
    endtask
    task automatic rdw(input logic cfg, input logic [14:0] a,
                       input logic [13:0] e);
        xfer(1'b1, 4'h2, a[7:0]);
        xfer(1'b1, 4'h3, {1'b0, a[14:8]});
        xfer(1'b1, 4'h4, {1'b0, cfg, 6'h01});
        rdc(4'h0, e[7:0]);
        rdc(4'h1, {2'b00, e[13:8]});
    endtask
    function automatic logic [13:0] cfg_exp(input int a);
        case (a)
            0, 1, 3: return 14'h3fff;
            2: return uid;
            6: return DID;
            7: return CW1;
            8: return CW2;
            default: return 14'h0000;
        endcase
    endfunction
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(32437));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(4'h4, 8'h80);
        rdc(4'h3, 8'h80);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            xfer(1'b1, 4'h1, d);
            rdc(4'h1, d & 8'h3f);
            xfer(1'b1, 4'h3, d);
            rdc(4'h3, d | 8'h80);
            xfer(1'b1, 4'h2, d);
            rdc(4'h2, d);
            xfer(1'b1, 4'(8 + i), d);
            rdc(4'(8 + i), 8'h00);
        end
        uid = 14'($urandom);
        op(8'h44, 15'h0002, uid, 1'b0);
        op(8'h44, 15'h0006, 14'h0000, 1'b0);
        for (int a = 0; a < 9; a++) rdw(1'b1, 15'(a), cfg_exp(a));
        row = {10'($urandom), 5'h00};
        w0 = 14'($urandom);
        w1 = 14'($urandom);
        w2 = 14'($urandom);
        xfer(1'b1, 4'h7, 8'h01);
        op(8'h24, row, w0, 1'b0);
        chk({15'h0, busy_seen}, 16'h0000);
        op(8'h24, row + 15'd2, w1, 1'b0);
        xfer(1'b0, 4'h6, 8'h00);
        op(8'h04, row + 15'd5, w2, 1'b0);
        chk({15'h0, busy_seen}, 16'h0001);
        rdc(4'h4, 8'h84);
        chk({15'h0, irq_seen}, 16'h0001);
        rdc(4'h6, 8'h01);
        rdc(4'h4, 8'h84);
        chk({15'h0, irq_seen}, 16'h0000);
        rdw(1'b0, row, w0);
        rdw(1'b0, row + 15'd1, 14'h3fff);
        rdw(1'b0, row + 15'd2, w1);
        rdw(1'b0, row + 15'd5, w2);
        op(8'h04, row ^ 15'h0020, w0, 1'b0);
        rdw(1'b0, row ^ 15'h0022, 14'h3fff);
        op(8'h34, row, 14'h0000, 1'b0);
        chk({15'h0, busy_seen}, 16'h0001);
        rdc(4'h4, 8'ha4);
        rdw(1'b0, row + 15'd5, 14'h3fff);
        op(8'h04, row, w1, 1'b1);
        chk({15'h0, busy_seen}, 16'h0000);
        rdc(4'h4, 8'h8c);
        rdc(4'h6, 8'h03);
        rdw(1'b0, row, 14'h3fff);
        op(8'h00, row, w1, 1'b0);
        chk({15'h0, busy_seen}, 16'h0000);
        rdc(4'h4, 8'h88);
        rdw(1'b0, row, 14'h3fff);
        xfer(1'b1, 4'h7, 8'h00);
        end_of_test();
    end
endmodule // fspc_flash_ctrl_test
